// ===== verilog/dds_port_pkg.sv
// Purpose: Constants shared by the serial write port of the synthesizer.
// Assumes: core_clk at 100 MHz samples the serial link pins.
// Notes:   Word layout is control nibble, address nibble, data byte.
//
// How it works
// - Each low period of frame select carries exactly one sixteen-bit word, loaded once the frame ends.
// - The shift clock runs at 40 MHz at most and the port captures correctly up to that rate.
// - A shift clock that runs freely or rests high or low between frames neither corrupts nor misframes words.
// - Words travel most significant bit first and a host that shifts LSB first reorders them beforehand.
// - A register word splits into a four-bit control field, a four-bit address field and an eight-bit data field.
// - Data is stable at the falling shift-clock edge and the port samples it there.
// - Two frequency registers exist and the frequency bank select input picks the active one.
// - Two phase registers exist and the phase bank select input picks the active one.
// - The synthesizer master clock stays at or below 16 MHz.
package dds_port_pkg;

  localparam int WORD_BITS      = 16;
  localparam int CTRL_MSB       = 15;
  localparam int CTRL_LSB       = 12;
  localparam int ADDR_MSB       = 11;
  localparam int ADDR_LSB       = 8;
  localparam int DATA_MSB       = 7;
  localparam int DATA_LSB       = 0;
  localparam int BIT_CNT_W      = 5;
  localparam int CORE_CLK_MHZ   = 100;
  localparam int SCLK_MAX_MHZ   = 40;
  localparam int MCLK_MAX_MHZ   = 16;
  localparam int SYNC_STAGES    = 2;
  localparam int BUF_DEPTH      = 2;

  // Address map of the bank registers and the control register within a word's address field.
  localparam logic [3:0] ADDR_FREQ0  = 4'h0;
  localparam logic [3:0] ADDR_FREQ1  = 4'h1;
  localparam logic [3:0] ADDR_PHASE0 = 4'h2;
  localparam logic [3:0] ADDR_PHASE1 = 4'h3;
  localparam logic [3:0] ADDR_CTRL   = 4'h4;

  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } frame_state_t;

endpackage

// ===== verilog/word_buffer.sv
// Purpose: Two-entry buffer carrying received words from the shifter to the registers.
// Assumes: One clock, valid/ready on both sides.
// Notes:   Read data come from a register; full and empty are exact.
`timescale 1ns/10ps
module word_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready  = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r        <= bump(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= bump(rd_ptr_r);
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// ===== verilog/dds_serial_write_port.sv
// Purpose: Receives sixteen-bit words over the three-wire link and loads the bank registers.
// Assumes: core_clk at 100 MHz oversamples the shift clock (40 MHz at most).
// Notes:   All link pins are synchronised before use; outputs are registered.
`timescale 1ns/10ps
module dds_serial_write_port
  import dds_port_pkg::*;
#(
  parameter int FREQ_W  = 28,
  parameter int PHASE_W = 12
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // Serial link
  input  wire logic                      frame_select_n,
  input  wire logic                      serial_clk,
  input  wire logic                      serial_data_in,
  // Bank selection pins
  input  wire logic                      freq_bank_select,
  input  wire logic                      phase_bank_select,
  // Received words
  output logic      [dds_port_pkg::WORD_BITS-1:0] word_out,
  output logic                           word_strobe,
  // Active tuning words, control byte and frame drop flag
  output logic      [FREQ_W-1:0]         freq_word,
  output logic      [PHASE_W-1:0]        phase_word,
  output logic      [7:0]                ctrl_byte,
  output logic                           frame_drop
);

  import dds_port_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] fs_sync_r;
  logic [SYNC_STAGES-1:0] ck_sync_r;
  logic [SYNC_STAGES-1:0] sd_sync_r;
  logic [SYNC_STAGES-1:0] fb_sync_r;
  logic [SYNC_STAGES-1:0] pb_sync_r;
  logic                   ck_prev_r;
  logic                   sd_prev_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fs_sync_r <= '1;
      ck_sync_r <= '1;
      sd_sync_r <= '0;
      fb_sync_r <= '0;
      pb_sync_r <= '0;
      ck_prev_r <= 1'b1;
      sd_prev_r <= 1'b0;
    end else begin
      fs_sync_r <= {fs_sync_r[0], frame_select_n};
      ck_sync_r <= {ck_sync_r[0], serial_clk};
      sd_sync_r <= {sd_sync_r[0], serial_data_in};
      fb_sync_r <= {fb_sync_r[0], freq_bank_select};
      pb_sync_r <= {pb_sync_r[0], phase_bank_select};
      ck_prev_r <= ck_sync_r[1];
      sd_prev_r <= sd_sync_r[1];
    end
  end

  wire frame_low = !fs_sync_r[1];
  wire ck_fall   = ck_prev_r && !ck_sync_r[1];
  // Data is taken one sample late so it lines up with the delayed clock edge.
  wire sample_d  = sd_prev_r;

  // ----------------------------------------------------------------
  // Frame state machine and shifter
  // ----------------------------------------------------------------
  frame_state_t           state_r;
  frame_state_t           state_nxt;
  logic [WORD_BITS-1:0]   shift_r;
  logic [BIT_CNT_W-1:0]   bit_cnt_r;
  logic                   buf_in_valid;
  logic                   buf_in_ready;
  logic                   buf_out_valid;
  logic [WORD_BITS-1:0]   buf_out_data;
  logic                   drop_r;

  wire word_full = (bit_cnt_r == BIT_CNT_W'(WORD_BITS));
  // Only falling edges inside a low frame count, so idle clock levels are harmless.
  wire take_bit  = (state_r == ST_SHIFT) && frame_low && ck_fall && !word_full;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (frame_low) state_nxt = ST_SHIFT;
      ST_SHIFT: if (!frame_low) state_nxt = word_full ? ST_DONE : ST_IDLE;
      ST_DONE:  if (buf_in_ready) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  assign buf_in_valid = (state_r == ST_DONE);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= ST_IDLE;
      shift_r   <= WORD_RESET;
      bit_cnt_r <= '0;
      drop_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      drop_r  <= (state_r == ST_SHIFT) && !frame_low && !word_full;
      if (state_r == ST_IDLE) begin
        bit_cnt_r <= '0;
      end else if (take_bit) begin
        shift_r   <= {shift_r[WORD_BITS-2:0], sample_d};
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Drain pacing
  // ----------------------------------------------------------------
  // A word leaves the buffer only after the previous one has stood long enough
  // for a master clock of at most 16 MHz to sample it; faster words wait instead of being lost.
  localparam int HOLD_CYCLES = (CORE_CLK_MHZ + MCLK_MAX_MHZ - 1) / MCLK_MAX_MHZ;

  logic [3:0] hold_cnt_r;

  wire drain_ok  = (hold_cnt_r == 4'h0);
  wire load_word = buf_out_valid && drain_ok;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt_r <= 4'h0;
    end else if (load_word) begin
      hold_cnt_r <= 4'(HOLD_CYCLES - 1);
    end else if (!drain_ok) begin
      hold_cnt_r <= hold_cnt_r - 4'h1;
    end
  end

  word_buffer #(
    .WIDTH (WORD_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (shift_r),
    .out_valid (buf_out_valid),
    .out_ready (drain_ok),
    .out_data  (buf_out_data)
  );

  // ----------------------------------------------------------------
  // Word decode and bank registers
  // ----------------------------------------------------------------
  logic [FREQ_W-1:0]  freq0_r;
  logic [FREQ_W-1:0]  freq1_r;
  logic [PHASE_W-1:0] phase0_r;
  logic [PHASE_W-1:0] phase1_r;
  logic [7:0]         ctrl_r;

  wire [3:0] w_ctrl = buf_out_data[CTRL_MSB:CTRL_LSB];
  wire [3:0] w_addr = buf_out_data[ADDR_MSB:ADDR_LSB];
  wire [7:0] w_data = buf_out_data[DATA_MSB:DATA_LSB];

  // Control nibble picks which byte lane of a wide bank register is written.
  function automatic logic [31:0] put_byte(input logic [31:0] old, input logic [3:0] lane,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = old;
    r[{lane[1:0], 3'b000} +: 8] = b;
    put_byte = r;
  endfunction

  // Unmapped addresses enable no register, so such words only show on word_out.
  wire wr_freq0  = load_word && (w_addr == ADDR_FREQ0);
  wire wr_freq1  = load_word && (w_addr == ADDR_FREQ1);
  wire wr_phase0 = load_word && (w_addr == ADDR_PHASE0);
  wire wr_phase1 = load_word && (w_addr == ADDR_PHASE1);
  wire wr_ctrl   = load_word && (w_addr == ADDR_CTRL);

  wire [FREQ_W-1:0]  freq0_nxt  = FREQ_W'(put_byte(32'(freq0_r), w_ctrl, w_data));
  wire [FREQ_W-1:0]  freq1_nxt  = FREQ_W'(put_byte(32'(freq1_r), w_ctrl, w_data));
  wire [PHASE_W-1:0] phase0_nxt = PHASE_W'(put_byte(32'(phase0_r), w_ctrl, w_data));
  wire [PHASE_W-1:0] phase1_nxt = PHASE_W'(put_byte(32'(phase1_r), w_ctrl, w_data));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      freq0_r  <= '0;
      freq1_r  <= '0;
      phase0_r <= '0;
      phase1_r <= '0;
      ctrl_r   <= '0;
    end else begin
      if (wr_freq0) begin
        freq0_r <= freq0_nxt;
      end
      if (wr_freq1) begin
        freq1_r <= freq1_nxt;
      end
      if (wr_phase0) begin
        phase0_r <= phase0_nxt;
      end
      if (wr_phase1) begin
        phase1_r <= phase1_nxt;
      end
      if (wr_ctrl) begin
        ctrl_r <= w_data;
      end
    end
  end

  // Bank pins pick the active tuning words once they are synchronised.
  wire [FREQ_W-1:0]  freq_sel  = fb_sync_r[1] ? freq1_r : freq0_r;
  wire [PHASE_W-1:0] phase_sel = pb_sync_r[1] ? phase1_r : phase0_r;

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      word_out    <= WORD_RESET;
      word_strobe <= 1'b0;
      freq_word   <= '0;
      phase_word  <= '0;
      ctrl_byte   <= '0;
      frame_drop  <= 1'b0;
    end else begin
      word_strobe <= load_word;
      if (load_word) begin
        word_out <= buf_out_data;
      end
      freq_word  <= freq_sel;
      phase_word <= phase_sel;
      ctrl_byte  <= ctrl_r;
      frame_drop <= drop_r;
    end
  end

endmodule

// ===== test/dds_port_props.sv
// Purpose: Port checks for the serial write port.
// Assumes: Frames are spaced by at least four core_clk cycles.
// Notes:   Bound to the top module after endmodule.
`timescale 1ns/10ps
module dds_port_props
  import dds_port_pkg::*;
#(
  parameter int FREQ_W  = 28,
  parameter int PHASE_W = 12
) (
  // Clock, reset, link and bank selection pins
  input wire logic                               core_clk,
  input wire logic                               rstn,
  input wire logic                               frame_select_n,
  input wire logic                               serial_clk,
  input wire logic                               serial_data_in,
  input wire logic                               freq_bank_select,
  input wire logic                               phase_bank_select,
  // Outputs
  input wire logic [dds_port_pkg::WORD_BITS-1:0] word_out,
  input wire logic                               word_strobe,
  input wire logic [FREQ_W-1:0]                  freq_word,
  input wire logic [PHASE_W-1:0]                 phase_word,
  input wire logic [7:0]                         ctrl_byte,
  input wire logic                               frame_drop
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_in_frame;
    !frame_select_n [*8];
  endsequence
  property p_strobe_pulse; word_strobe |=> !word_strobe; endproperty
  property p_drop_pulse; frame_drop |=> !frame_drop; endproperty
  property p_one_outcome; !(word_strobe && frame_drop); endproperty
  property p_strobe_after_end; word_strobe |-> $past(frame_select_n, 4); endproperty
  property p_drop_after_end; frame_drop |-> $past(frame_select_n, 4); endproperty
  property p_word_with_strobe; $changed(word_out) |-> word_strobe; endproperty
  property p_ctrl_address; $changed(ctrl_byte) |-> word_out[11:8] == ADDR_CTRL; endproperty
  property p_quiet_in_frame; s_in_frame |-> !word_strobe && !frame_drop; endproperty
  property p_strobe_spacing; word_strobe |=> !word_strobe [*6]; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("word strobe longer than one cycle");
  a_drop_pulse: assert property (p_drop_pulse) else $error("drop pulse longer than one cycle");
  a_one_outcome: assert property (p_one_outcome) else $error("frame both loaded and dropped");
  a_strobe_after_end: assert property (p_strobe_after_end) else $error("word loaded inside a frame");
  a_drop_after_end: assert property (p_drop_after_end) else $error("drop flagged inside a frame");
  a_word_with_strobe: assert property (p_word_with_strobe) else $error("word changed without strobe");
  a_ctrl_address: assert property (p_ctrl_address) else $error("control byte changed by other address");
  a_quiet_in_frame: assert property (p_quiet_in_frame) else $error("result during an open frame");
  a_strobe_spacing: assert property (p_strobe_spacing) else $error("tuning words loaded too close together");
endmodule
bind dds_serial_write_port dds_port_props #(.FREQ_W(FREQ_W), .PHASE_W(PHASE_W)) i_props (.*);

// ===== test/dds_host_model.sv
// Purpose: Host side of the three-wire link.
// Assumes: 80 ns shift clock, resting still outside frames unless free_clock runs it.
// Notes:   Data line shows the inverse of its last bit when released.
`timescale 1ns/10ps
module dds_host_model (
  // Link pins
  output logic frame_select_n,
  output logic serial_clk,
  output logic serial_data_in
);
  initial begin
    frame_select_n = 1'b1;
    serial_clk     = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int nbits, input bit split, input bit idle_low);
    frame_select_n = 1'b0;
    #40;
    for (int i = 0; i < nbits; i++) begin
      serial_data_in = w[15-i];
      serial_clk     = 1'b1;
      #40;
      serial_clk = 1'b0;
      #40;
      if (split && i == 7) begin
        serial_clk = 1'b1;
        #200;
      end
    end
    #40;
    frame_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    serial_clk     = ~idle_low;
  endtask
  task automatic free_clock(input int periods);
    for (int i = 0; i < periods; i++) begin
      serial_clk = 1'b0;
      #40;
      serial_clk = 1'b1;
      #40;
    end
  endtask
endmodule

// ===== test/dds_serial_write_port_bench.sv
// Purpose: Self-checking bench for the serial write port.
// Assumes: Host model drives the link; bank pins driven here.
// Notes:   Outputs sampled on the falling core_clk edge.
`timescale 1ns/10ps
module dds_serial_write_port_bench;
  import dds_port_pkg::*;
  logic core_clk, rstn, fbs, pbs, fsn, sclk, sdi, strobe, drop;
  logic [15:0] word;
  logic [27:0] freq;
  logic [11:0] phase;
  logic [7:0]  ctrl;
  int fails = 0;
  int total_checks = 0;
  dds_host_model i_host (.frame_select_n(fsn), .serial_clk(sclk), .serial_data_in(sdi));
  dds_serial_write_port i_dut (.core_clk(core_clk), .rstn(rstn), .frame_select_n(fsn), .serial_clk(sclk),
    .serial_data_in(sdi), .freq_bank_select(fbs), .phase_bank_select(pbs), .word_out(word),
    .word_strobe(strobe), .freq_word(freq), .phase_word(phase), .ctrl_byte(ctrl), .frame_drop(drop));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
      fails++;
    end
  endtask
  task automatic send(input logic [15:0] w, input int n, input bit split, input bit idle_low);
    int s, d;
    s = 0;
    d = 0;
    @(posedge core_clk);
    #1;
    i_host.send(w, n, split, idle_low);
    for (int i = 0; i < 30; i++) begin
      @(negedge core_clk);
      s += (strobe === 1'b1);
      d += (drop === 1'b1);
    end
    chk("word_strobe", (n == 16), s);
    chk("frame_drop", (n != 16), d);
    if (n == 16) chk("word_out", w, word);
  endtask
  task automatic free_run;
    int s;
    s = 0;
    @(posedge core_clk);
    #1;
    fork
      i_host.free_clock(8);
      repeat (64) begin
        @(negedge core_clk);
        s += (strobe === 1'b1) + (drop === 1'b1);
      end
    join
    chk("results_outside_frame", 0, s);
  endtask
  task automatic sel(input logic f, input logic p);
    @(posedge core_clk);
    #1;
    fbs = f;
    pbs = p;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic t_freq;
    send(16'h00A5, 16, 0, 0);
    send(16'h113C, 16, 0, 1);
    sel(0, 0);
    chk("freq_word", 28'h00000A5, freq);
    sel(1, 0);
    chk("freq_word", 28'h0003C00, freq);
    $display("test freq banks done");
  endtask
  task automatic t_phase;
    send(16'h120F, 16, 0, 0);
    send(16'h0377, 16, 0, 0);
    sel(0, 0);
    chk("phase_word", 12'hF00, phase);
    sel(0, 1);
    chk("phase_word", 12'h077, phase);
    $display("test phase banks done");
  endtask
  task automatic t_split;
    send(16'h045A, 16, 1, 0);
    chk("ctrl_byte", 8'h5A, ctrl);
    $display("test split word done");
  endtask
  task automatic t_short;
    send(16'h04FF, 9, 0, 1);
    send(16'h09EE, 16, 0, 0);
    chk("ctrl_byte", 8'h5A, ctrl);
    chk("phase_word", 12'h077, phase);
    $display("test short and unmapped done");
  endtask
  task automatic t_free;
    free_run();
    send(16'h2112, 16, 0, 0);
    free_run();
    chk("word_out", 16'h2112, word);
    sel(1, 1);
    chk("freq_word", 28'h0123C00, freq);
    chk("phase_word", 12'h077, phase);
    $display("test running clock done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    fbs  = 1'b0;
    pbs  = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge core_clk);
    t_freq();
    t_phase();
    t_split();
    t_short();
    t_free();
    summarize();
  end
  initial begin
    #200000;
    fails++;
    summarize();
  end
endmodule
